// ==== asgcr_pkg.sv ====
// constants, types and register map of the converter sampling and gain configuration bank
// assumes a single 40 MHz clock domain and an APB master on the register side
package asgcr_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_SAMPLING_CONFIG = 6'h03;
   localparam logic [5:0] IDX_CHANNEL_GAIN_CONFIG = 6'h04;
   localparam logic [5:0] IDX_RESERVED_WORD = 6'h05;
   localparam logic [5:0] IDX_EFFECTIVE_STATUS = 6'h07;
   localparam int ADDR_W = 12;

   // reset values
   localparam logic [15:0] RST_SAMPLING_CONFIG = 16'h0F0E;
   localparam logic [15:0] RST_CHANNEL_GAIN_CONFIG = 16'h0000;
   localparam logic [15:0] RST_RESERVED_WORD = 16'h0000;

   // sampling_config field positions
   localparam int POS_CONV_ENABLE_LO = 8;
   localparam int POS_TURBO = 5;
   localparam int POS_OSR_LO = 2;
   localparam int POS_POWER_LO = 0;
   localparam logic [15:0] MASK_SAMPLING_WRITABLE = 16'h0FFF;

   // channel_gain_config field positions, one nibble per lane
   localparam int POS_GAIN_LANE_STEP = 4;
   localparam int NUM_LANES = 4;

   // oversampling ratio figures
   localparam logic [14:0] OSR_TURBO = 15'h0040;
   localparam logic [14:0] OSR_BASE = 15'h0080;
   localparam logic [3:0] OSR_EXP_TURBO = 4'h6;
   localparam logic [3:0] OSR_EXP_BASE = 4'h7;

   // power modes
   typedef enum logic [1:0] {
      PM_VERY_LOW_POWER,
      PM_LOW_POWER,
      PM_HIGH_RESOLUTION
   } asgcr_power_t;

   // configuration carried to modulators, decimators and amplifiers
   typedef struct packed {
      logic [NUM_LANES-1:0] conv_enable;
      logic turbo_active;
      logic [14:0] oversample_ratio;
      logic [3:0] oversample_exp;
      asgcr_power_t power_mode;
      logic [NUM_LANES-1:0][2:0] amp_gain_code;
      logic [NUM_LANES-1:0][7:0] amp_gain_factor;
   } asgcr_cfg_t;

endpackage : asgcr_pkg

// ==== asgcr_osr_decode.sv ====
// oversampling ratio and power mode decoder
// assumes fields come straight from the sampling_config register
`timescale 1ns/1ps
`default_nettype none
module asgcr_osr_decode
   import asgcr_pkg::*;
(
   input wire logic i_turbo,
   input wire logic [2:0] i_osr_code,
   input wire logic [1:0] i_power_code,
   output logic [14:0] o_ratio,
   output logic [3:0] o_exp,
   output asgcr_power_t o_power
);

   always_comb begin
      if (i_turbo) begin
         o_ratio = OSR_TURBO;
         o_exp = OSR_EXP_TURBO;
      end else begin
         o_ratio = OSR_BASE << i_osr_code;
         o_exp = OSR_EXP_BASE + {1'b0, i_osr_code};
      end
   end

   always_comb begin
      unique case (i_power_code)
         2'h0: o_power = PM_VERY_LOW_POWER;
         2'h1: o_power = PM_LOW_POWER;
         2'h2, 2'h3: o_power = PM_HIGH_RESOLUTION;
      endcase
   end

endmodule : asgcr_osr_decode
`default_nettype wire

// ==== asgcr_gain_decode.sv ====
// amplifier gain decoder for one lane
// assumes a three-bit power-of-two gain code
`timescale 1ns/1ps
`default_nettype none
module asgcr_gain_decode
   import asgcr_pkg::*;
(
   input wire logic [2:0] i_code,
   output logic [7:0] o_factor
);

   // code n gives a gain of two to the n
   assign o_factor = 8'h01 << i_code;

endmodule : asgcr_gain_decode
`default_nettype wire

// ==== asgcr_regs.sv ====
// sampling-control, amplifier gain and reserved registers of a four-lane converter
// assumes an APB master on i_clock; outputs feed modulators, decimators and amplifiers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module asgcr_regs
   import asgcr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output asgcr_cfg_t o_cfg,
   output logic o_cfg_update
);

   // stored registers
   logic [15:0] sampling_config;
   logic [15:0] channel_gain_config;
   logic [15:0] reserved_word;

   // bus decode
   logic addr_aligned;
   logic [5:0] addr_index;
   logic hit_sampling;
   logic hit_gain;
   logic hit_reserved;
   logic hit_status;
   logic addr_hit;
   logic access;
   logic wr_access;
   logic rd_setup;

   // decoded configuration
   logic [14:0] osr_ratio;
   logic [3:0] osr_exp;
   asgcr_power_t power_mode;
   logic [NUM_LANES-1:0][2:0] gain_code;
   logic [NUM_LANES-1:0][7:0] gain_factor;
   asgcr_cfg_t next_cfg;
   logic [15:0] effective_status;
   logic [2:0] lanes_enabled;

   // byte-strobe merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old_value,
                                           input logic [31:0] wdata,
                                           input logic [3:0] strb);
      logic [15:0] result;
      result = old_value;
      if (strb[0]) begin
         result[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         result[15:8] = wdata[15:8];
      end
      return result;
   endfunction : merge16

   // number of set bits among the lane enables
   function automatic logic [2:0] count_lanes(input logic [NUM_LANES-1:0] en);
      logic [2:0] total;
      total = 3'h0;
      for (int i = 0; i < NUM_LANES; i++) begin
         total = total + {2'h0, en[i]};
      end
      return total;
   endfunction : count_lanes

   // address decode; only aligned words map
   assign addr_aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:8] == '0);
   assign addr_index = i_paddr[7:2];
   assign hit_sampling = addr_aligned && (addr_index == IDX_SAMPLING_CONFIG);
   assign hit_gain = addr_aligned && (addr_index == IDX_CHANNEL_GAIN_CONFIG);
   assign hit_reserved = addr_aligned && (addr_index == IDX_RESERVED_WORD);
   assign hit_status = addr_aligned && (addr_index == IDX_EFFECTIVE_STATUS);
   assign addr_hit = hit_sampling || hit_gain || hit_reserved || hit_status;

   // zero-wait slave
   assign o_pready = 1'b1;
   assign access = i_psel && i_penable;
   assign wr_access = access && i_pwrite && addr_hit;
   assign rd_setup = i_psel && !i_penable && !i_pwrite;
   assign o_pslverr = access && !addr_hit;

   // sampling-control register
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sampling_config <= RST_SAMPLING_CONFIG;
      end else if (wr_access && hit_sampling) begin
         sampling_config <= merge16(sampling_config, i_pwdata, i_pstrb)
                            & MASK_SAMPLING_WRITABLE;
      end
   end

   // amplifier gain register
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         channel_gain_config <= RST_CHANNEL_GAIN_CONFIG;
      end else if (wr_access && hit_gain) begin
         channel_gain_config <= merge16(channel_gain_config, i_pwdata, i_pstrb);
      end
   end

   // reserved word, stored but unused
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         reserved_word <= RST_RESERVED_WORD;
      end else if (wr_access && hit_reserved) begin
         reserved_word <= merge16(reserved_word, i_pwdata, i_pstrb);
      end
   end

   // ratio and power decode
   asgcr_osr_decode u_osr_decode (
      .i_turbo(sampling_config[POS_TURBO]),
      .i_osr_code(sampling_config[POS_OSR_LO +: 3]),
      .i_power_code(sampling_config[POS_POWER_LO +: 2]),
      .o_ratio(osr_ratio),
      .o_exp(osr_exp),
      .o_power(power_mode)
   );

   // per-lane gain fields at bits 4*n+2..4*n
   for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      assign gain_code[g] = channel_gain_config[g*POS_GAIN_LANE_STEP +: 3];
      asgcr_gain_decode u_gain_decode (
         .i_code(gain_code[g]),
         .o_factor(gain_factor[g])
      );
   end

   // next configuration image
   always_comb begin
      next_cfg.conv_enable = sampling_config[POS_CONV_ENABLE_LO +: NUM_LANES];
      next_cfg.turbo_active = sampling_config[POS_TURBO];
      next_cfg.oversample_ratio = osr_ratio;
      next_cfg.oversample_exp = osr_exp;
      next_cfg.power_mode = power_mode;
      next_cfg.amp_gain_code = gain_code;
      next_cfg.amp_gain_factor = gain_factor;
   end

   // registered configuration outputs
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_cfg <= '0;
         o_cfg.conv_enable <= RST_SAMPLING_CONFIG[POS_CONV_ENABLE_LO +: NUM_LANES];
         o_cfg.oversample_ratio <= OSR_BASE << RST_SAMPLING_CONFIG[POS_OSR_LO +: 3];
         o_cfg.oversample_exp <= OSR_EXP_BASE + {1'b0, RST_SAMPLING_CONFIG[POS_OSR_LO +: 3]};
         o_cfg.power_mode <= PM_HIGH_RESOLUTION;
         o_cfg.amp_gain_factor <= {NUM_LANES{8'h01}};
      end else begin
         o_cfg <= next_cfg;
      end
   end

   // one-cycle pulse when the applied configuration changes
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_cfg_update <= 1'b0;
      end else begin
         o_cfg_update <= (next_cfg != o_cfg);
      end
   end

   // effective state readback
   assign lanes_enabled = count_lanes(sampling_config[POS_CONV_ENABLE_LO +: NUM_LANES]);
   assign effective_status = {5'h00, lanes_enabled, 2'h0, o_cfg.power_mode, o_cfg.oversample_exp};

   // read data captured in the setup cycle
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         unique case (1'b1)
            hit_sampling: o_prdata <= {16'h0000, sampling_config};
            hit_gain: o_prdata <= {16'h0000, channel_gain_config};
            hit_reserved: o_prdata <= {16'h0000, reserved_word};
            hit_status: o_prdata <= {16'h0000, effective_status};
            default: o_prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : asgcr_regs
`default_nettype wire

// ==== asgcr_regs_checker.sv ====
// assertions on the ports of the sampling and gain register bank
// bound into asgcr_regs; single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module asgcr_regs_checker
   import asgcr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire asgcr_cfg_t o_cfg,
   input wire logic o_cfg_update
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence s_wr_sc;
      i_psel && i_penable && i_pwrite && i_paddr == 12'h00C;
   endsequence
   sequence s_wr_gn;
      i_psel && i_penable && i_pwrite && i_paddr == 12'h010 && i_pstrb[1:0] == 2'h3;
   endsequence
   property p_rst;
      $rose(i_rst_n) |-> o_cfg.conv_enable == 4'hF && !o_cfg.turbo_active &&
         o_cfg.oversample_ratio == 15'h0400 && o_cfg.power_mode == PM_HIGH_RESOLUTION;
   endproperty
   property p_en;
      s_wr_sc ##0 i_pstrb[1] |-> ##2 o_cfg.conv_enable == $past(i_pwdata[11:8], 2);
   endproperty
   property p_tbw;
      s_wr_sc ##0 (i_pstrb[0] && i_pwdata[5]) |-> ##2 o_cfg.oversample_ratio == 15'h0040;
   endproperty
   property p_osr;
      s_wr_sc ##0 (i_pstrb[0] && !i_pwdata[5]) |->
         ##2 o_cfg.oversample_ratio == (15'h0080 << $past(i_pwdata[4:2], 2));
   endproperty
   property p_pwr;
      s_wr_sc ##0 i_pstrb[0] |-> ##2 o_cfg.power_mode == ($past(i_pwdata[1], 2) ?
         PM_HIGH_RESOLUTION : ($past(i_pwdata[0], 2) ? PM_LOW_POWER : PM_VERY_LOW_POWER));
   endproperty
   property p_g0;
      s_wr_gn |-> ##2 o_cfg.amp_gain_factor[0] == (8'h01 << $past(i_pwdata[2:0], 2));
   endproperty
   property p_gn;
      s_wr_gn |-> ##2 o_cfg.amp_gain_code[1] == $past(i_pwdata[6:4], 2) &&
         o_cfg.amp_gain_code[2] == $past(i_pwdata[10:8], 2) &&
         o_cfg.amp_gain_code[3] == $past(i_pwdata[14:12], 2);
   endproperty
   property p_rd;
      i_psel && i_penable && !i_pwrite && i_paddr == 12'h00C |-> o_prdata[31:12] == 20'h00000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset decode wrong");
   a_en: assert property (p_en) else $error("lane enables wrong");
   a_tbw: assert property (p_tbw) else $error("turbo ratio wrong");
   a_osr: assert property (p_osr) else $error("ratio decode wrong");
   a_pwr: assert property (p_pwr) else $error("power decode wrong");
   a_g0: assert property (p_g0) else $error("lane 0 gain wrong");
   a_gn: assert property (p_gn) else $error("lane 1 to 3 gain wrong");
   a_rd: assert property (p_rd) else $error("upper control bits not zero");
   property p_upd;
      $changed(o_cfg) |-> o_cfg_update;
   endproperty
   a_upd: assert property (p_upd) else $error("update pulse missing");
endmodule : asgcr_regs_checker
bind asgcr_regs asgcr_regs_checker u_chk(.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_cfg, .o_cfg_update);
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the sampling and gain register bank
// drives the APB port directly; the checker is attached by bind
`timescale 1ns/1ps
`default_nettype none
module testbench
   import asgcr_pkg::*;
;
   typedef struct packed {
      logic [11:0] a;
      logic [15:0] w;
      logic [15:0] r;
      logic [14:0] osr;
      asgcr_power_t pm;
   } asgcr_row_t;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [ADDR_W-1:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, q;
   logic [3:0] i_pstrb = '0;
   logic o_pready, o_pslverr, o_cfg_update, e;
   asgcr_cfg_t o_cfg;
   int fail_count = 0, comparisons = 0, cycles = 0;
   asgcr_row_t rows [12] = '{
      '{12'h00C, 16'hF000, 16'h0000, 15'h0080, PM_VERY_LOW_POWER},
      '{12'h00C, 16'h0105, 16'h0105, 15'h0100, PM_LOW_POWER},
      '{12'h00C, 16'h020A, 16'h020A, 15'h0200, PM_HIGH_RESOLUTION},
      '{12'h00C, 16'h030F, 16'h030F, 15'h0400, PM_HIGH_RESOLUTION},
      '{12'h00C, 16'h0410, 16'h0410, 15'h0800, PM_VERY_LOW_POWER},
      '{12'h00C, 16'h0814, 16'h0814, 15'h1000, PM_VERY_LOW_POWER},
      '{12'h00C, 16'h0C18, 16'h0C18, 15'h2000, PM_VERY_LOW_POWER},
      '{12'h00C, 16'h00DC, 16'h00DC, 15'h4000, PM_VERY_LOW_POWER},
      '{12'h00C, 16'h0F3C, 16'h0F3C, 15'h0040, PM_VERY_LOW_POWER},
      '{12'h010, 16'h7654, 16'h7654, 15'h0000, PM_VERY_LOW_POWER},
      '{12'h010, 16'h0123, 16'h0123, 15'h0000, PM_VERY_LOW_POWER},
      '{12'h014, 16'hA5A5, 16'hA5A5, 15'h0000, PM_VERY_LOW_POWER}};
   always #12.5 i_clock = ~i_clock;
   asgcr_regs DUT(.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_cfg, .o_cfg_update);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge i_clock);
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} <= {2'b10, w, a, 16'h0, d, s};
      @(posedge i_clock);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         finish_test();
      end
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      apb(1'b0, 12'h00C, 16'h0, 4'h0);
      chk(q, 32'h00000F0E);
      chk(32'(o_cfg.oversample_ratio), 32'h400);
      chk(32'(o_cfg.conv_enable), 32'hF);
      apb(1'b0, 12'h010, 16'h0, 4'h0);
      chk(q, 32'h0);
      apb(1'b0, 12'h014, 16'h0, 4'h0);
      chk(q, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w, 4'h3);
         apb(1'b0, rows[i].a, 16'h0, 4'h0);
         chk(q, {16'h0, rows[i].r});
         if (rows[i].a == 12'h00C) begin
            chk(32'(o_cfg.oversample_ratio), 32'(rows[i].osr));
            chk(32'(o_cfg.power_mode), 32'(rows[i].pm));
            chk(32'(o_cfg.conv_enable), 32'(rows[i].w[11:8]));
         end
         if (rows[i].a == 12'h010) begin
            chk(32'(o_cfg.amp_gain_factor[0]), 32'h1 << rows[i].w[2:0]);
            chk(32'(o_cfg.amp_gain_code[1]), 32'(rows[i].w[6:4]));
            chk(32'(o_cfg.amp_gain_code[2]), 32'(rows[i].w[10:8]));
            chk(32'(o_cfg.amp_gain_factor[3]), 32'h1 << rows[i].w[14:12]);
         end
      end
      $display("test table done");
      apb(1'b1, 12'h00C, 16'h0, 4'h2);
      apb(1'b1, 12'h00D, 16'h0F00, 4'h3);
      chk(32'(e), 32'h1);
      apb(1'b0, 12'h00C, 16'h0, 4'h0);
      chk(q, 32'h0000003C);
      chk(32'(o_cfg.oversample_ratio), 32'h40);
      chk(32'(o_cfg.oversample_exp), 32'h6);
      chk(32'(o_cfg.turbo_active), 32'h1);
      chk(32'(o_pready), 32'h1);
      apb(1'b0, 12'h01C, 16'h0, 4'h0);
      chk(q, 32'h00000006);
      chk(32'(e), 32'h0);
      apb(1'b1, 12'h100, 16'hFFFF, 4'h3);
      chk(32'(e), 32'h1);
      apb(1'b0, 12'h100, 16'h0, 4'h0);
      chk(q, 32'h0);
      $display("test strobes and errors done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
